// ===== inc/collector_map.svh
// Address codes, register offsets, field positions and timing for the data collector
`ifndef COLLECTOR_MAP_SVH
`define COLLECTOR_MAP_SVH

// Slave address type codes
`define TYPE_MEM       4'ha
`define TYPE_RTC       4'hd

// Clock register offsets
`define RA_FLAGS       4'h0
`define RA_CALCTL      4'h1
`define RA_SEC         4'h2
`define RA_MIN         4'h3
`define RA_HOUR        4'h4
`define RA_DAY         4'h5
`define RA_DATE        4'h6
`define RA_MONTH       4'h7
`define RA_YEAR        4'h8

// Field positions
`define F_TAMPER       7
`define F_CALMODE      2
`define F_OSC_OFF      7

// Reset values, offsets 0 to 8
`define TK_RESET '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00}

// Oscillator divider: 15 bits give one second, bit 5 toggles at 512 Hz
`define SEC_DIV_W      15
`define CAL_DIV_BIT    5

// Supply hold-off time and the clock rate
`define RESET_HOLDOFF_TIME_MS 100
`define CLK_KHZ        100000

`endif

// ===== inc/collector_pkg.sv
// Types shared by the data collector modules
package collector_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_mack} bus_state_t;
endpackage

// ===== logic/byte_store.sv
// Byte-wide array with registered read data
`timescale 1ns/1ps
module byte_store #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          mclk,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];   // Storage, no reset on purpose

  // Write at once, read one cycle behind the address
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== logic/dual_id_two_wire_data_collector.sv
// Two-wire slave with memory and clock identities, plus supply supervisor
// How it works
// RULE1: Answer only when select bits match pins.
// RULE2: Type code 1010 selects the memory.
// RULE3: Type code 1101 selects clock registers.
// RULE4: Clock accesses leave memory pointer alone.
// RULE5: Sample on rising clock, drive on falling.
// RULE6: Master sends 16-bit word address first.
// RULE7: Only lower 15 address bits select bytes.
// RULE8: Master should send address MSB as zero.
// RULE9: Memory writes finish at bus speed.
// RULE10: Sequential writes have no page limit.
// RULE11: Address increments per byte, wraps to zero.
// RULE12: Intrusion rising edge sets tamper flag.
// RULE13: Tamper flag clears only by software write.
// RULE14: Calibration pin gives 512 Hz square wave.
// RULE15: Timekeeping counts a 32.768 kHz oscillator.
// RULE16: BCD time seconds to years, calibration mode.
// RULE17: Leap years handled correctly through 2099.
// RULE18: Nine backed registers keep running on battery.
// RULE19: Reset held low, plus 100 ms hold-off.
// RULE20: Low supply ignores every bus access.
// RULE21: Supervisor independent of register accesses.
// RULE22: Weekday ring counts one to seven.
`timescale 1ns/1ps
`include "collector_map.svh"
module dual_id_two_wire_data_collector #(
  parameter int AW             = 15,
  parameter int HOLDOFF_CYCLES = `RESET_HOLDOFF_TIME_MS * `CLK_KHZ
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Two-wire bus, data is open drain
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] chip_select_pins,
  // Timekeeping pins
  input  wire logic       osc_pins,
  input  wire logic       intrusion_input,
  output logic            cal_out,
  // Supply monitor, open-drain reset to the host
  input  wire logic       supply_below_trip,
  output logic            host_rst_n_out,
  output logic            host_rst_n_oe
);
  import collector_pkg::*;

  localparam int HW = $clog2(HOLDOFF_CYCLES + 1);

  bus_state_t    state_reg;      // Bus engine state
  bus_state_t    state_next;
  logic [3:0]    bit_reg;        // Bit count within a byte
  logic [3:0]    bit_next;
  byte_t         shift_reg;      // Received byte
  byte_t         shift_next;
  byte_t         tx_reg;         // Byte being sent
  byte_t         tx_next;
  logic [1:0]    phase_reg;      // 0 id, 1 and 2 address, 3 data
  logic [1:0]    phase_next;
  logic          rtc_reg;        // Clock identity chosen
  logic          rtc_next;
  logic          read_reg;       // Read direction
  logic          read_next;
  logic [AW-1:0] ptr_reg;        // Memory pointer, kept across clock accesses
  logic [AW-1:0] ptr_next;
  logic [3:0]    rptr_reg;       // Clock register pointer
  logic [3:0]    rptr_next;
  logic          oe_reg;         // Data line pulled low
  logic          oe_next;
  logic          scl_q_reg;      // Previous line levels
  logic          sda_q_reg;
  logic [HW-1:0] hold_reg;       // Hold-off countdown
  logic [HW-1:0] hold_next;

  logic          scl_rise;
  logic          scl_fall;
  logic          start_cond;
  logic          stop_cond;
  logic          id_match;
  logic          mem_we;
  logic          rtc_we;
  byte_t         mem_rdata;
  byte_t         rtc_rdata;
  byte_t         rd_byte;

  // Line events seen against the previous sample
  assign scl_rise   = scl & ~scl_q_reg;
  assign scl_fall   = ~scl & scl_q_reg;
  assign start_cond = scl & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_cond  = scl & scl_q_reg & ~sda_q_reg & sda_in;
  // Pins pick the device, never the memory location
  assign id_match   = (shift_reg[3:1] == chip_select_pins) &&   // see RULE1
                      (shift_reg[7:4] == `TYPE_MEM || shift_reg[7:4] == `TYPE_RTC);   // see RULE2 RULE3
  assign rd_byte    = rtc_reg ? rtc_rdata : mem_rdata;
  assign sda_out    = 1'b0;
  assign sda_oe     = oe_reg & ~supply_below_trip;   // see RULE20
  assign host_rst_n_out = 1'b0;

  // Bus engine
  always_comb begin
    state_next = state_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    tx_next    = tx_reg;
    phase_next = phase_reg;
    rtc_next   = rtc_reg;
    read_next  = read_reg;
    ptr_next   = ptr_reg;
    rptr_next  = rptr_reg;
    oe_next    = oe_reg;
    mem_we     = 1'b0;
    rtc_we     = 1'b0;
    if (supply_below_trip) begin
      // Whole interface deaf while supply is low
      state_next = st_idle;   // see RULE20
      oe_next    = 1'b0;
    end else if (start_cond) begin
      // Start or repeated start keeps both pointers
      state_next = st_rx;
      bit_next   = 4'h0;
      phase_next = 2'd0;
      oe_next    = 1'b0;
    end else if (stop_cond) begin
      state_next = st_idle;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        st_rx: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_in};   // see RULE5
            bit_next   = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            state_next = st_ack;
            oe_next    = 1'b1;
            if (phase_reg == 2'd0) begin
              // Identity byte: ack only our own
              if (id_match) begin
                rtc_next  = (shift_reg[7:4] == `TYPE_RTC);
                read_next = shift_reg[0];
              end else begin
                state_next = st_idle;
                oe_next    = 1'b0;
              end
            end else if (rtc_reg) begin
              // Clock side: one register address, then data
              if (phase_reg == 2'd1) begin
                rptr_next  = shift_reg[3:0];   // see RULE4
                phase_next = 2'd3;
              end else begin
                rtc_we    = 1'b1;
                rptr_next = (rptr_reg >= `RA_YEAR) ? 4'h0 : rptr_reg + 4'h1;
              end
            end else if (phase_reg == 2'd1) begin
              // High address byte, top bit has no location behind it
              ptr_next[AW-1:8] = shift_reg[AW-9:0];   // see RULE6 RULE7
              phase_next       = 2'd2;
            end else if (phase_reg == 2'd2) begin
              ptr_next[7:0] = shift_reg;
              phase_next    = 2'd3;
            end else begin
              // No busy time, no page boundary
              mem_we   = 1'b1;   // see RULE9 RULE10
              ptr_next = ptr_reg + 1'b1;   // see RULE11
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (read_reg && phase_reg == 2'd0) begin
              // First read byte goes out on this falling edge
              state_next = st_tx;
              tx_next    = rd_byte;
              oe_next    = ~rd_byte[7];
              phase_next = 2'd3;
              if (rtc_reg) begin
                rptr_next = (rptr_reg >= `RA_YEAR) ? 4'h0 : rptr_reg + 4'h1;
              end else begin
                ptr_next = ptr_reg + 1'b1;   // see RULE11
              end
            end else begin
              state_next = st_rx;
              oe_next    = 1'b0;
              if (phase_reg == 2'd0) begin
                phase_next = 2'd1;
              end
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              state_next = st_mack;
              oe_next    = 1'b0;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              oe_next = ~tx_reg[6];   // see RULE5
            end
          end
        end
        st_mack: begin
          if (scl_rise && sda_in) begin
            // Master declined, wait for stop
            state_next = st_idle;
          end else if (scl_fall) begin
            state_next = st_tx;
            bit_next   = 4'h0;
            tx_next    = rd_byte;
            oe_next    = ~rd_byte[7];
            if (rtc_reg) begin
              rptr_next = (rptr_reg >= `RA_YEAR) ? 4'h0 : rptr_reg + 4'h1;
            end else begin
              ptr_next = ptr_reg + 1'b1;   // see RULE11
            end
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Bus engine registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= st_idle;
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      phase_reg <= 2'd0;
      rtc_reg   <= 1'b0;
      read_reg  <= 1'b0;
      ptr_reg   <= '0;
      rptr_reg  <= 4'h0;
      oe_reg    <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      phase_reg <= phase_next;
      rtc_reg   <= rtc_next;
      read_reg  <= read_next;
      ptr_reg   <= ptr_next;
      rptr_reg  <= rptr_next;
      oe_reg    <= oe_next;
      scl_q_reg <= scl;
      sda_q_reg <= sda_in;
    end
  end

  // Supervisor: reloads while low, counts down after recovery
  always_comb begin
    hold_next = hold_reg;
    if (supply_below_trip) begin
      hold_next = HW'(HOLDOFF_CYCLES);   // see RULE19
    end else if (hold_reg != '0) begin
      hold_next = hold_reg - 1'b1;
    end
  end

  // Nothing on the bus reaches this counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_reg <= HW'(HOLDOFF_CYCLES);   // see RULE21
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign host_rst_n_oe = supply_below_trip | (hold_reg != '0);   // see RULE19

  // Memory array
  byte_store #(
    .AW (AW),
    .DW (8)
  ) u_store (
    .mclk  (mclk),
    .we    (mem_we),
    .addr  (ptr_reg),
    .wdata (shift_reg),
    .rdata (mem_rdata)
  );

  // Clock, calendar and tamper
  timekeeper u_time (
    .mclk      (mclk),
    .rst       (rst),
    .osc_in    (osc_pins),
    .intrusion (intrusion_input),
    .cal_out   (cal_out),
    .we        (rtc_we),
    .addr      (rptr_reg),
    .wdata     (shift_reg),
    .rdata     (rtc_rdata),
    .tamper    ()
  );

  chk_low_deaf: assert property (@(posedge mclk) disable iff (rst) // see RULE20
    supply_below_trip |=> state_reg == st_idle && !sda_oe)
    else $error("bus active while supply low");
  chk_reset_low: assert property (@(posedge mclk) disable iff (rst) // see RULE19
    supply_below_trip |-> host_rst_n_oe)
    else $error("reset released while supply low");
  chk_holdoff_run: assert property (@(posedge mclk) disable iff (rst) // see RULE19
    $fell(supply_below_trip) |-> host_rst_n_oe [*8])
    else $error("hold-off cut short");
  chk_holdoff_end: assert property (@(posedge mclk) disable iff (rst) // see RULE21
    hold_reg == HW'(1) && !supply_below_trip ##1 !supply_below_trip |-> !host_rst_n_oe)
    else $error("reset held past hold-off");
  chk_rtc_ptr_kept: assert property (@(posedge mclk) disable iff (rst) // see RULE4
    rtc_reg && state_reg != st_idle |=> $stable(ptr_reg))
    else $error("memory pointer moved on clock access");
  chk_id_ack: assert property (@(posedge mclk) disable iff (rst) // see RULE1
    state_reg == st_ack && phase_reg == 2'd0 |-> shift_reg[3:1] == chip_select_pins)
    else $error("acknowledged a foreign select code");
  chk_type_code: assert property (@(posedge mclk) disable iff (rst) // see RULE3
    state_reg == st_ack && phase_reg == 2'd0 |-> rtc_reg == (shift_reg[7:4] == `TYPE_RTC))
    else $error("identity chosen from wrong type code");
  chk_ptr_wrap: assert property (@(posedge mclk) disable iff (rst) // see RULE11
    mem_we && ptr_reg == '1 |=> ptr_reg == '0)
    else $error("memory pointer did not wrap");
  chk_write_ack: assert property (@(posedge mclk) disable iff (rst) // see RULE9
    mem_we ##1 !supply_below_trip |-> sda_oe && state_reg == st_ack)
    else $error("memory write not acknowledged at once");
  chk_drive_fall: assert property (@(posedge mclk) disable iff (rst) // see RULE5
    state_reg == st_tx && $changed(oe_reg) && !$past(start_cond) |-> $past(scl_fall))
    else $error("data changed outside falling clock");
  cov_mem_write: cover property (@(posedge mclk) disable iff (rst) mem_we);
  cov_rtc_read: cover property (@(posedge mclk) disable iff (rst) rtc_reg && state_reg == st_tx);
  cov_mem_read: cover property (@(posedge mclk) disable iff (rst) !rtc_reg && state_reg == st_mack);
  cov_holdoff: cover property (@(posedge mclk) disable iff (rst) $fell(host_rst_n_oe));
endmodule

// ===== logic/timekeeper.sv
// Clock, calendar, tamper latch and calibration output
`timescale 1ns/1ps
`include "collector_map.svh"
module timekeeper #(
  parameter int DIV_W = `SEC_DIV_W
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Pins
  input  wire logic                 osc_in,
  input  wire logic                 intrusion,
  output logic                      cal_out,
  // Register port from the bus engine
  input  wire logic                 we,
  input  wire logic [3:0]           addr,
  input  wire collector_pkg::byte_t wdata,
  output collector_pkg::byte_t      rdata,
  output logic                      tamper
);
  import collector_pkg::*;

  byte_t             tk_reg [0:8];   // Nine backed-up registers
  byte_t             tk_next [0:8];
  logic [DIV_W-1:0]  div_reg;        // Oscillator prescaler
  logic [DIV_W-1:0]  div_next;
  logic              osc_q_reg;      // Previous oscillator level
  logic              intr_q_reg;     // Previous intrusion level
  logic              cal_reg;
  logic              cal_next;
  logic              osc_rise;
  logic              intr_rise;
  logic              tick;

  // BCD step of one register
  function automatic byte_t bcd_inc(input byte_t v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Last date of the month; every fourth year leaps, right through 2099
  function automatic byte_t last_date(input byte_t m, input byte_t y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      return leap ? 8'h29 : 8'h28;   // see RULE17
    end
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  assign osc_rise  = osc_in & ~osc_q_reg;
  assign intr_rise = intrusion & ~intr_q_reg;
  assign tamper    = tk_reg[`RA_FLAGS][`F_TAMPER];
  assign cal_out   = cal_reg;
  assign rdata     = (addr <= `RA_YEAR) ? tk_reg[addr] : 8'h00;

  // Counting, host writes, tamper capture
  always_comb begin
    tk_next  = tk_reg;
    div_next = div_reg;
    tick     = 1'b0;
    // Oscillator stop bit freezes the prescaler
    if (osc_rise && !tk_reg[`RA_CALCTL][`F_OSC_OFF]) begin   // see RULE15
      div_next = div_reg + 1'b1;
      tick     = &div_reg;
    end
    // BCD cascade seconds to years, see RULE16
    if (tick) begin
      tk_next[`RA_SEC] = bcd_inc(tk_reg[`RA_SEC]);
      if (tk_reg[`RA_SEC] == 8'h59) begin
        tk_next[`RA_SEC] = 8'h00;
        tk_next[`RA_MIN] = bcd_inc(tk_reg[`RA_MIN]);
        if (tk_reg[`RA_MIN] == 8'h59) begin
          tk_next[`RA_MIN]  = 8'h00;
          tk_next[`RA_HOUR] = bcd_inc(tk_reg[`RA_HOUR]);
          if (tk_reg[`RA_HOUR] == 8'h23) begin
            tk_next[`RA_HOUR] = 8'h00;
            // Weekday ring runs on its own, not tied to the date
            tk_next[`RA_DAY] = (tk_reg[`RA_DAY] == 8'h07) ? 8'h01 : tk_reg[`RA_DAY] + 8'h01;   // see RULE22
            tk_next[`RA_DATE] = bcd_inc(tk_reg[`RA_DATE]);
            if (tk_reg[`RA_DATE] == last_date(tk_reg[`RA_MONTH], tk_reg[`RA_YEAR])) begin
              tk_next[`RA_DATE]  = 8'h01;
              tk_next[`RA_MONTH] = bcd_inc(tk_reg[`RA_MONTH]);
              if (tk_reg[`RA_MONTH] == 8'h12) begin
                tk_next[`RA_MONTH] = 8'h01;
                tk_next[`RA_YEAR]  = (tk_reg[`RA_YEAR] == 8'h99) ? 8'h00 : bcd_inc(tk_reg[`RA_YEAR]);
              end
            end
          end
        end
      end
    end
    // Host write wins over the count for its own register
    if (we && addr <= `RA_YEAR) begin   // see RULE18
      tk_next[addr] = wdata;
      if (addr == `RA_FLAGS) begin
        // Tamper flag only clears, never set by software
        tk_next[`RA_FLAGS][`F_TAMPER] = tk_reg[`RA_FLAGS][`F_TAMPER] & wdata[`F_TAMPER];   // see RULE13
      end
    end
    // Edge sets the flag even in the clearing cycle
    if (intr_rise) begin
      tk_next[`RA_FLAGS][`F_TAMPER] = 1'b1;   // see RULE12
    end
    // Square wave only in calibration mode
    cal_next = tk_reg[`RA_FLAGS][`F_CALMODE] & div_reg[`CAL_DIV_BIT];   // see RULE14
  end

  // State registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tk_reg     <= `TK_RESET;
      div_reg    <= '0;
      osc_q_reg  <= 1'b0;
      intr_q_reg <= 1'b0;
      cal_reg    <= 1'b0;
    end else begin
      tk_reg     <= tk_next;
      div_reg    <= div_next;
      osc_q_reg  <= osc_in;
      intr_q_reg <= intrusion;
      cal_reg    <= cal_next;
    end
  end

  chk_tamper_set: assert property (@(posedge mclk) disable iff (rst) intr_rise |=> tamper) // see RULE12
    else $error("tamper edge not latched");
  chk_tamper_sticky: assert property (@(posedge mclk) disable iff (rst) // see RULE13
    tamper && !(we && addr == `RA_FLAGS && !wdata[`F_TAMPER]) |=> tamper)
    else $error("tamper flag dropped without software clear");
  chk_day_ring: assert property (@(posedge mclk) disable iff (rst) // see RULE22
    tick && tk_reg[`RA_HOUR] == 8'h23 && tk_reg[`RA_MIN] == 8'h59 && tk_reg[`RA_SEC] == 8'h59
    && tk_reg[`RA_DAY] == 8'h07 && !we |=> tk_reg[`RA_DAY] == 8'h01)
    else $error("weekday ring did not return to one");
  chk_cal_quiet: assert property (@(posedge mclk) disable iff (rst) // see RULE14
    !tk_reg[`RA_FLAGS][`F_CALMODE] |=> !cal_out)
    else $error("calibration output active outside calibration mode");
  cov_tamper: cover property (@(posedge mclk) disable iff (rst) $rose(tamper));
endmodule

// ===== testbench/dual_id_two_wire_data_collector_tb.sv
// Self-checking bench for the two-identity data collector
`timescale 1ns/1ps
`include "collector_map.svh"
module dual_id_two_wire_data_collector_tb;
  import collector_pkg::*;
  logic       mclk, rst, scl, m_pull, osc, intr, low, cal_q;
  logic [2:0] sel;
  wire logic  sda_oe, host_oe, cal, sda_lvl, rst_lvl;
  wire logic  sda = ~(sda_oe | m_pull);  // Pull-up on the data line
  int         n_mismatch, n_checks, ptr_m;
  int         tog = 0;                   // Calibration pin changes
  byte_t      mem_m [int];               // Expected memory contents

  // Hold-off shortened to 20 cycles
  dual_id_two_wire_data_collector #(.HOLDOFF_CYCLES(20)) dut (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_lvl), .sda_oe(sda_oe),
    .chip_select_pins(sel), .osc_pins(osc), .intrusion_input(intr), .cal_out(cal),
    .supply_below_trip(low), .host_rst_n_out(rst_lvl), .host_rst_n_oe(host_oe));
  two_wire_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(m_pull));

  // Verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Byte comparison
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single flag comparison
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Start plus slave address, ack compared with the expectation
  task automatic open_id(input logic [3:0] code, input logic [2:0] s, input logic rd, input logic exp);
    logic ack;
    m.start();
    m.put_byte({code, s, rd}, ack);
    chk_bit("id ack", exp, ack);
  endtask

  // Memory write of n random bytes from word address a
  task automatic mem_wr(input logic [15:0] a, input int n);
    logic  ack;
    byte_t d;
    open_id(`TYPE_MEM, sel, 1'b0, 1'b1);  // Memory identity
    m.put_byte(a[15:8], ack);  // Two address bytes first
    m.put_byte(a[7:0], ack);
    ptr_m = int'(a[14:0]);  // Top bit dropped
    repeat (n) begin
      d = byte_t'($urandom);
      m.put_byte(d, ack);
      chk_bit("write ack", 1'b1, ack);  // Every byte taken at once
      mem_m[ptr_m] = d;
      ptr_m = (ptr_m + 1) % 32768;  // Wraps to zero
    end
    m.stop();
  endtask

  // Current-address memory read of n bytes
  task automatic mem_rd(input int n);
    byte_t d;
    open_id(`TYPE_MEM, sel, 1'b1, 1'b1);  // Memory identity
    for (int i = 1; i <= n; i++) begin
      m.get_byte(i < n, d);
      chk("memory byte", mem_m[ptr_m], d);  // Follows the pointer
      ptr_m = (ptr_m + 1) % 32768;
    end
    m.stop();
  endtask

  // Clock register write and read
  task automatic rtc_wr(input byte_t r, input byte_t v);
    logic ack;
    open_id(`TYPE_RTC, sel, 1'b0, 1'b1);  // Clock identity
    m.put_byte(r, ack);
    m.put_byte(v, ack);
    m.stop();
  endtask
  task automatic rtc_rd(input byte_t r, output byte_t d);
    logic ack;
    open_id(`TYPE_RTC, sel, 1'b0, 1'b1);  // Clock identity
    m.put_byte(r, ack);
    open_id(`TYPE_RTC, sel, 1'b1, 1'b1);  // Repeated start to read
    m.get_byte(1'b0, d);
    m.stop();
  endtask

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Count level changes of the calibration pin outside reset
  always @(posedge mclk) begin
    if (!rst && cal !== cal_q) tog++;
    cal_q <= cal;
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    results();
  end

  // Main sequence
  initial begin
    byte_t d;
    rst = 1'b1;
    osc = 1'b0;
    intr = 1'b0;
    low = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(29027));
    sel = 3'($urandom);
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    chk_bit("host reset", 1'b1, host_oe);  // Still in hold-off
    repeat (20) @(negedge mclk);
    chk_bit("host reset", 1'b0, host_oe);  // Hold-off over
    // Writes across the top of the array, no page limit
    mem_wr(16'hfffe, 4);  // Top bit ignored, wrap
    mem_wr(16'h7ffe, 0);  // Pointer set only
    mem_rd(2);  // Read back up to the top
    rtc_wr(`RA_FLAGS, 8'h04);  // Enable calibration output
    rtc_rd(`RA_FLAGS, d);
    chk("flags", 8'h04, d);  // Clock register kept
    mem_rd(2);  // Continues after the clock access
    // Every type code plus wrong select bits
    for (int c = 0; c < 16; c++) begin
      open_id(4'(c), sel, 1'b0, c == `TYPE_MEM || c == `TYPE_RTC);  // Only two codes answer
      m.stop();
    end
    open_id(`TYPE_MEM, sel ^ 3'h1, 1'b0, 1'b0);  // Pins must match
    m.stop();
    open_id(`TYPE_RTC, sel ^ 3'h4, 1'b0, 1'b0);  // Pins must match
    m.stop();
    // Intrusion edge latch
    intr = 1'b1;
    repeat (4) @(negedge mclk);
    intr = 1'b0;
    rtc_rd(`RA_FLAGS, d);
    chk("flags", 8'h84, d);  // Edge sets the flag
    rtc_rd(`RA_FLAGS, d);
    chk("flags", 8'h84, d);  // Input low again, flag kept
    rtc_wr(`RA_FLAGS, 8'h04);
    rtc_rd(`RA_FLAGS, d);
    chk("flags", 8'h04, d);  // Cleared by a write
    chk_bit("host reset", 1'b0, host_oe);  // Untouched by accesses
    // 64 oscillator edges give one full calibration period
    repeat (64) begin
      repeat (4) @(negedge mclk);
      osc = 1'b1;
      repeat (4) @(negedge mclk);
      osc = 1'b0;
    end
    repeat (8) @(negedge mclk);
    chk("calibration toggles", 8'h02, byte_t'(tog));  // Divide by 64
    // Supply below trip
    low = 1'b1;
    open_id(`TYPE_MEM, sel, 1'b0, 1'b0);  // Access ignored
    m.stop();
    chk_bit("host reset", 1'b1, host_oe);  // Asserted while low
    low = 1'b0;
    repeat (15) @(negedge mclk);
    chk_bit("host reset", 1'b1, host_oe);  // Hold-off after recovery
    repeat (10) @(negedge mclk);
    chk_bit("host reset", 1'b0, host_oe);  // Released after hold-off
    rtc_rd(`RA_FLAGS, d);
    chk("flags", 8'h04, d);  // Answers again
    chk_bit("data pin level", 1'b0, sda_lvl);  // Open drain, low when driven
    chk_bit("reset pin level", 1'b0, rst_lvl);  // Active low when driven
    results();
  end
endmodule

// ===== testbench/two_wire_master.sv
// Bus master model that drives the collector's two-wire port
`timescale 1ns/1ps
module two_wire_master (
  // Clock
  input  wire logic mclk,
  // Bus lines, sda_pull high pulls data low
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Idle bus: clock high and still, data released
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Every line change lands just after a falling edge
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One bit: data set while clock low, read back at clock high
  task automatic bit_io(input logic b, output logic seen);
    hold(4);
    sda_pull = ~b;  // Change only while clock low
    hold(4);
    scl = 1'b1;
    hold(4);
    seen = sda;  // Sampled after the rise
    hold(4);
    scl = 1'b0;
  endtask

  // Start or repeated start; data falls while clock high
  task automatic start();
    hold(4);
    sda_pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask

  // Stop; data rises while clock high, then the bus stands idle
  task automatic stop();
    hold(4);
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b0;
    hold(4);
  endtask

  // Send a byte MSB first, then release for the device's ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Receive a byte; ack it low when more bytes are wanted
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule
